/* dst_defines.svh */
// Register offsets, field positions, reset values and limits of the transmitter
`ifndef DST_DEFINES_SVH
`define DST_DEFINES_SVH

// Register byte offsets on the APB port
`define DST_OFF_CTRL      8'h00
`define DST_OFF_CFG       8'h04
`define DST_OFF_STATUS    8'h08

// Control register fields
`define DST_CTRL_EN       0

// Configuration register fields
`define DST_CFG_FACT_LSB  0
`define DST_CFG_FACT_MSB  3
`define DST_CFG_DIV_LSB   4
`define DST_CFG_DIV_MSB   7
`define DST_CFG_PH_LSB    8
`define DST_CFG_PH_MSB    10
`define DST_CFG_CLK_MODE  11
`define DST_CFG_BYP_LSB   12
`define DST_CFG_BYP_MSB   13

// Status register fields
`define DST_ST_RUN        0
`define DST_ST_ERR        1
`define DST_ST_CNT_LSB    8
`define DST_ST_CNT_MSB    11

// Reset values
`define DST_CTRL_RST      32'h0000_0000
`define DST_CFG_RST       32'h0000_001A

// Serialization limits and word width
`define DST_FACTOR_MIN    4'h3
`define DST_FACTOR_MAX    4'hA
`define DST_WORD_W        10

`endif

/* dst_pkg.sv */
// Types shared by the differential serializer transmitter
package dst_pkg;

   // Output path selection
   typedef enum logic [1:0] {
      BYP_NONE,
      BYP_SDR,
      BYP_DDR
   } dst_byp_e;

   // Channel state
   typedef enum logic {
      ST_IDLE,
      ST_RUN
   } dst_state_e;

   // Static channel configuration
   typedef struct packed {
      dst_byp_e   bypass;
      logic       clk_mode;
      logic [2:0] phase;
      logic [3:0] div;
      logic [3:0] factor;
   } dst_cfg_s;

endpackage

/* dst_serializer_tx.sv */
// Serializer, forwarded clock and bypass path of one differential tx channel
//
// Operation
// - Capture word up to ten bits, shift out
// - Most significant bit goes out first
// - Load and shift run on bit clock
// - Factor three to ten, static while running
// - New word every factor bit periods
// - Channel may forward clock instead of data
// - Forwarded clock can toggle at data rate
// - Clock divide 1,2,4,6,8,10, factor dependent
// - Clock phase 0 or 180 degrees
// - Further phase offsets in 45 degree steps, rounded down to whole bit periods
// - Bypass gives factor two or one
// - Two pad cell registers, DDR or SDR
// - DDR and SDR both registered on clock
`timescale 1ns/1ns
`default_nettype none
`include "dst_defines.svh"

module dst_serializer_tx
   import dst_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic [9:0]  word_i,
   output logic             word_load_o,
   output logic             tx_o,
   output logic      [1:0]  pad_ddr_o
);

   dst_state_e state;
   dst_cfg_s   cfg_reg;
   dst_cfg_s   act;
   logic       ctrl_en;
   logic       cfg_err;
   logic [9:0] sreg;
   logic [3:0] cnt;
   logic [4:0] ccnt;
   logic [31:0] rd_mux;
   logic       rd_err;
   logic       acc;
   logic       run;
   logic       start;
   logic       serial_mode;
   logic [9:0] aligned;
   logic [6:0] ph_off;

   // Legal factor and a divide that lands on whole word boundaries
   function automatic logic cfg_ok(input dst_cfg_s c);
      logic fact_ok;
      logic div_ok;
      fact_ok = (c.factor >= `DST_FACTOR_MIN) && (c.factor <= `DST_FACTOR_MAX);
      div_ok  = (c.div == 4'h1) || (c.div == 4'h2) || (c.div == 4'h4)
                || (c.div == 4'h6) || (c.div == 4'h8) || (c.div == 4'hA);
      if (c.clk_mode && div_ok && c.div != 4'h1) begin
         div_ok = ({c.factor, 1'b0} % {1'b0, c.div}) == 5'h00;
      end
      return (c.bypass != BYP_NONE) || (fact_ok && (!c.clk_mode || div_ok));
   endfunction

   assign run         = (state == ST_RUN);
   assign acc         = psel_i && penable_i && pready_o;
   assign start       = (state == ST_IDLE) && ctrl_en && cfg_ok(cfg_reg);
   assign serial_mode = (act.bypass == BYP_NONE) && !act.clk_mode;
   // Word sits low in word_i; push its top bit to position nine
   assign aligned     = word_i << (4'hA - act.factor);
   // Offset in bit periods for a 45 degree step of a 2*div period
   assign ph_off      = 7'(cfg_reg.phase * cfg_reg.div) >> 2;

   // APB answers one cycle into the access phase
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pready_o  <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else if (psel_i && penable_i && !pready_o) begin
         pready_o  <= 1'b1;
         prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
         pslverr_o <= rd_err;
      end else begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end

   // Read decode; unmapped addresses answer with an error and zero data
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      if (paddr_i == `DST_OFF_CTRL) begin
         rd_mux[`DST_CTRL_EN] = ctrl_en;
      end else if (paddr_i == `DST_OFF_CFG) begin
         rd_mux[13:0] = cfg_reg;
      end else if (paddr_i == `DST_OFF_STATUS) begin
         rd_mux[`DST_ST_RUN] = run;
         rd_mux[`DST_ST_ERR] = cfg_err;
         rd_mux[`DST_ST_CNT_MSB:`DST_ST_CNT_LSB] = cnt;
      end else begin
         rd_err = 1'b1;
      end
   end

   // Software registers; configuration is frozen while the channel runs
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ctrl_en <= 1'(`DST_CTRL_RST);
         cfg_reg <= 14'(`DST_CFG_RST);
      end else if (acc && pwrite_i) begin
         if (paddr_i == `DST_OFF_CTRL) begin
            ctrl_en <= pwdata_i[`DST_CTRL_EN];
         end else if (paddr_i == `DST_OFF_CFG && !run) begin
            cfg_reg <= pwdata_i[13:0];
         end
      end
   end

   // Channel state; active settings latched once at start
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state   <= ST_IDLE;
         act     <= 14'(`DST_CFG_RST);
         cfg_err <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  act     <= cfg_reg;
                  state   <= ST_RUN;
                  cfg_err <= 1'b0;
               end else if (ctrl_en) begin
                  cfg_err <= 1'b1;
               end
            end
            ST_RUN: begin
               if (!ctrl_en) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Forwarded clock phase counter, preset to the chosen offset
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ccnt <= 5'h00;
      end else if (start) begin
         ccnt <= 5'(ph_off);
      end else if (run) begin
         ccnt <= (ccnt >= {act.div, 1'b0} - 5'h01) ? 5'h00 : ccnt + 5'h01;
      end
   end

   // Output path: serializer, clock forwarding or pad cell bypass
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sreg        <= 10'h000;
         cnt         <= 4'h0;
         word_load_o <= 1'b0;
         tx_o        <= 1'b0;
         pad_ddr_o   <= 2'h0;
      end else if (!run) begin
         // idle low, first load right after start
         sreg        <= 10'h000;
         cnt         <= 4'h0;
         tx_o        <= 1'b0;
         pad_ddr_o   <= 2'h0;
         word_load_o <= start && !cfg_reg.clk_mode;
      end else if (act.clk_mode) begin
         word_load_o <= 1'b0;
         tx_o        <= (ccnt < {1'b0, act.div});
      end else if (act.bypass == BYP_DDR) begin
         word_load_o <= 1'b1;
         pad_ddr_o   <= word_i[1:0];
         tx_o        <= word_i[1];
      end else if (act.bypass == BYP_SDR) begin
         word_load_o <= 1'b1;
         pad_ddr_o   <= {1'b0, word_i[0]};
         tx_o        <= word_i[0];
      end else if (word_load_o) begin
         tx_o        <= aligned[9];
         sreg        <= aligned << 1;
         cnt         <= act.factor - 4'h1;
         word_load_o <= 1'b0;
      end else if (cnt != 4'h0) begin
         tx_o        <= sreg[9];
         sreg        <= sreg << 1;
         cnt         <= cnt - 4'h1;
         word_load_o <= (cnt == 4'h1);
      end
   end

   // Helper counters watched only by the checks below
   logic [3:0] gap;
   logic [4:0] hold;
   logic       tx_d;
   logic       arm;
   logic       seen;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !run) begin
         gap  <= 4'h0;
         hold <= 5'h00;
         tx_d <= 1'b0;
         arm  <= 1'b0;
         seen <= 1'b0;
      end else begin
         tx_d <= tx_o;
         if (word_load_o) begin
            gap <= 4'h1;
         end else if (gap != 4'h0 && gap != 4'hF) begin
            gap <= gap + 4'h1;
         end
         // Phase preset may cut the first half period short, so the
         // check only trusts segments from the second edge onward
         if (tx_o != tx_d) begin
            hold <= 5'h01;
            arm  <= 1'b1;
            seen <= arm;
         end else if (hold != 5'h1F) begin
            hold <= hold + 5'h01;
         end
      end
   end

   AST_MSB_FIRST: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      run && serial_mode && word_load_o |=>
         tx_o == $past(word_i[act.factor - 4'h1]))
      else $error("first serial bit is not the word MSB");

   AST_SHIFT_ORDER: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      run && serial_mode && !word_load_o && cnt != 4'h0 && ctrl_en |=>
         tx_o == $past(sreg[9]))
      else $error("serial bit does not follow shift register");

   AST_LOAD_SPACING: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      run && serial_mode && word_load_o && gap != 4'h0 |->
         {1'b0, gap} == {1'b0, act.factor})
      else $error("word load spacing differs from factor");

   AST_IDLE_LEVEL: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      !run ##1 !run |-> !tx_o && pad_ddr_o == 2'h0)
      else $error("output not idle while stopped");

   AST_FACTOR_FROZEN: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      run && $past(run) |-> act == $past(act)
         && (act.bypass != BYP_NONE || act.factor >= `DST_FACTOR_MIN))
      else $error("active configuration changed while running");

   AST_CLOCK_DIV: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      run && act.clk_mode && seen && tx_o != tx_d |->
         hold == {1'b0, act.div})
      else $error("forwarded clock half period differs from divide");

   AST_SDR_PASS: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      run && act.bypass == BYP_SDR && !act.clk_mode ##1 run |->
         tx_o == $past(word_i[0]))
      else $error("single rate bypass bit lost");

   AST_DDR_PAIR: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      run && act.bypass == BYP_DDR && !act.clk_mode ##1 run |->
         pad_ddr_o == $past(word_i[1:0]) && tx_o == pad_ddr_o[1])
      else $error("double rate pad registers not loaded");

   AST_BYP_LOAD_LEVEL: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      run && act.bypass != BYP_NONE && !act.clk_mode |-> word_load_o)
      else $error("bypass word strobe dropped while running");

   AST_CLK_NO_LOAD: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      run && act.clk_mode |-> !word_load_o)
      else $error("word strobe raised in clock output mode");

   AST_APB_ANSWER: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
      psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
      else $error("APB answer not one cycle after access start");

endmodule

`default_nettype wire

/* dst_rx_model.sv */
// Receiver model that deserializes the transmitted bit stream
`timescale 1ns/1ns
`default_nettype none

module dst_rx_model (
   input  wire logic       ref_clk_i,
   input  wire logic       rx_i,
   output logic      [9:0] word_o
);
   always_ff @(posedge ref_clk_i) begin
      word_o <= {word_o[8:0], rx_i};
   end
endmodule

`default_nettype wire

/* tb.sv */
// Self-checking bench for the serializer transmitter
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic        ref_clk_i, rst_i, psel, penable, pwrite;
   logic        pready, pslverr, word_load, tx, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  pad_ddr;
   logic [9:0]  word, rxw;
   logic [15:0] v, w;
   int          n_mismatch, compares;
   int          dv[4] = '{1, 4, 8, 2};
   logic [31:0] bad[3] = '{32'h0000_0012, 32'h0000_001B, 32'h0000_0845};

   dst_serializer_tx u_dst_serializer_tx (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .word_i(word), .word_load_o(word_load),
      .tx_o(tx), .pad_ddr_o(pad_ddr));

   dst_rx_model u_dst_rx_model (
      .ref_clk_i(ref_clk_i), .rx_i(tx), .word_o(rxw));

   // Free-running bit clock, 100 ns period
   initial begin
      ref_clk_i = 1'h0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   task automatic final_report;
      if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // Wait bounded for a high level at a rising edge
   task automatic wait_hi(input bit apb_side);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while ((apb_side ? pready : word_load) !== 1'h1 && n < 60);
      if ((apb_side ? pready : word_load) !== 1'h1) begin
         n_mismatch++;
         final_report();
      end
   endtask

   // One APB transfer; request held until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk_i);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'h1;
      wait_hi(1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic start(input logic [31:0] c);
      apb(1'h1, 8'h04, c);
      apb(1'h1, 8'h00, 32'h0000_0001);
   endtask

   // Disable; the line must fall back to idle
   task automatic stop;
      apb(1'h1, 8'h00, 32'h0000_0000);
      repeat (3) @(posedge ref_clk_i);
      chk(tx, 1'h0);
   endtask

   task automatic ser(input int f, input logic [9:0] d);
      logic [9:0] m;
      m = 10'((1 << f) - 1);
      word <= d;
      start(32'h0000_0010 | 32'(f));
      wait_hi(0);
      word <= ~d;
      for (int i = 1; i <= 2 * f + 1; i++) begin
         @(posedge ref_clk_i);
         if (i <= 2 * f) chk(word_load, (i % f) == 0);
         if (i % f == 1 && i > 1) begin
            chk(rxw & m, (i > f + 1 ? ~d : d) & m);
         end
      end
      stop();
   endtask

   // Sample sixteen bits of forwarded clock
   task automatic clk_run(input int dvv, input int ph,
                          output logic [15:0] s);
      start(32'h0000_0804 | 32'(dvv << 4) | 32'(ph << 8));
      repeat (4) @(posedge ref_clk_i);
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk_i);
         s[i] = tx;
      end
      chk(word_load, 1'h0);
      stop();
   endtask

   initial begin
      rst_i = 1'h1;
      {psel, penable, pwrite} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      word = 10'h000;
      n_mismatch = 0;
      compares = 0;
      repeat (12) @(posedge ref_clk_i);
      rst_i <= 1'h0;
      chk(tx, 1'h0);
      apb(1'h0, 8'h04, 32'h0000_0000);
      chk(rd, 32'h0000_001A);
      apb(1'h0, 8'h0C, 32'h0000_0000);
      chk(er, 1'h1);
      chk(rd, 32'h0000_0000);
      ser(3, 10'h005);
      ser(10, 10'h2C5);
      // Factor 2, factor 11, and divide 4 against factor 5
      foreach (bad[i]) begin
         start(bad[i]);
         apb(1'h0, 8'h08, 32'h0000_0000);
         chk(rd[1:0], 2'h2);
         stop();
      end
      foreach (dv[j]) begin
         clk_run(dv[j], 0, v);
         for (int i = 0; i + dv[j] < 16; i++) begin
            chk(v[i + dv[j]], !v[i]);
         end
      end
      // Last run above was divide 2; a 180 degree step inverts it
      clk_run(2, 4, w);
      chk(w, 16'(~v));
      clk_run(4, 0, v);
      clk_run(4, 2, w);
      chk(w[11:0], v[13:2]);
      for (int k = 1; k <= 2; k++) begin
         word <= (k == 2) ? 10'h002 : 10'h003;
         start(32'(k << 12) | 32'h0000_001A);
         repeat (4) @(posedge ref_clk_i);
         chk({word_load, tx}, 2'h3);
         chk(pad_ddr, (k == 2) ? 2'h2 : 2'h1);
         stop();
      end
      final_report();
   end
endmodule

`default_nettype wire
